// *** pkg/spfic_map.svh ***
// register offsets, limits, reset values and timing constants
`ifndef SPFIC_MAP_SVH
`define SPFIC_MAP_SVH
`define SPFIC_A_CFG 4'h0
`define SPFIC_A_DIV 4'h1
`define SPFIC_A_TMO 4'h2
`define SPFIC_A_COL 4'h3
`define SPFIC_A_RST 4'h4
`define SPFIC_A_ID 4'h5
`define SPFIC_A_TXD 4'h6
`define SPFIC_A_RXD 4'h7
`define SPFIC_A_STS 4'h8
`define SPFIC_A_CMD 4'h9
`define SPFIC_DIV_RST 20'h00823
`define SPFIC_DIV_MIN 20'h00087
`define SPFIC_DIV_MAX 20'hCB735
`define SPFIC_OFF_MAX 7'h63
`define SPFIC_COL_MAX 10'h3E7
`define SPFIC_HR_MIN 7'h01
`define SPFIC_HR_MAX 7'h63
`define SPFIC_ID_MAX 17'h0FFFF
`define SPFIC_CLK_HZ 250000000
`define SPFIC_MS_NS 1000000
`define SPFIC_CLK_NS 4
`define SPFIC_MS_CYC (`SPFIC_MS_NS / `SPFIC_CLK_NS)
`define SPFIC_MIN_MS 60000
`define SPFIC_HR_MIN_CNT 60
`define SPFIC_RPT_LEN 4'h8
`define SPFIC_LF 8'h0A
`define SPFIC_CR 8'h0D
`define SPFIC_ASC0 8'h30
`define SPFIC_ASCA 8'h41
`define SPFIC_FIFO_D 4
`endif

// *** pkg/spfic_pkg.sv ***
// types shared by the serial port block
`default_nettype none
package spfic_pkg;
   typedef enum logic [2:0] {
      SPFIC_PAR_NONE, SPFIC_PAR_EVEN, SPFIC_PAR_ODD,
      SPFIC_PAR_SPACE, SPFIC_PAR_MARK
   } spfic_par_t;
   typedef enum logic [2:0] {
      SPFIC_IF_232, SPFIC_IF_232HS, SPFIC_IF_485, SPFIC_IF_422,
      SPFIC_IF_AUTO
   } spfic_if_t;
   typedef struct packed {
      logic [1:0] port_sel;
      logic rpt_en;
      spfic_if_t intf;
      logic two_stop;
      logic [1:0] dbits;
      spfic_par_t parity;
   } spfic_cfg_t;
   typedef struct packed {
      logic txd;
      logic rts;
      logic de;
   } spfic_line_t;
endpackage
`default_nettype wire

// *** design/spfic_fifo.sv ***
// small first-in first-out buffer with valid and ready on both sides
`default_nettype none
module spfic_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   // clocking
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wp_reg, rp_reg;
   logic [AW:0] cnt_reg;
   logic push, pop;
   assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
   assign out_valid = (cnt_reg != '0);
   assign out_data = mem[rp_reg];
   assign push = ce && in_valid && in_ready;
   assign pop = ce && out_valid && out_ready;
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wp_reg] <= in_data;
      end
   end
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wp_reg <= '0;
         rp_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wp_reg <= (wp_reg == AW'(DEPTH-1)) ? '0 : wp_reg + 1'b1;
         end
         if (pop) begin
            rp_reg <= (rp_reg == AW'(DEPTH-1)) ? '0 : rp_reg + 1'b1;
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule
`default_nettype wire

// *** design/spfic_top.sv ***
// serial port framing, line modes, idle timers and id report
`include "spfic_map.svh"
`default_nettype none
// Overview of operation
// - baud divisor covers 300 to 1953125 bps
// - parity none, even, odd, space, mark
// - five to eight data bits, one/two stops
// - plain mode ignores and drives no handshake
// - handshake mode: cts pauses, rts signals room
// - half duplex: rts enables driver while sending
// - full duplex sends and receives together
// - auto mode picks full or half duplex
// - off-line timeout 0 to 99 minutes
// - collect periods 0 to 999 milliseconds
// - auto restart after 1 to 99 idle hours
// - id report sent on socket connect
// - report: five digits, port letter, lf, cr
// - line feed 10 then carriage return 13
// - id 0 to 65535, report switchable
module spfic_top (
   // clocking
   input wire logic mclk,
   input wire logic rstn,
   input wire logic ce,
   // register port
   input wire logic [3:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   // serial line
   input wire logic rxd,
   input wire logic cts,
   input wire logic dev_4wire,
   output spfic_pkg::spfic_line_t line,
   // network side events
   input wire logic sock_conn,
   output logic off_line,
   output logic restart_req,
   output logic rx_pkt_rdy,
   output logic tx_pkt_go
);
   import spfic_pkg::*;
   spfic_cfg_t cfg_reg;
   logic [19:0] div_reg;
   logic [6:0] off_reg, hr_reg;
   logic [9:0] ctx_reg, crx_reg;
   logic [15:0] id_reg;
   spfic_if_t eff_if;
   logic half;
   // configuration writes; out of range divisor, timeout, collect and restart values are clipped, the id keeps its low 16 bits
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         cfg_reg <= '0;
         div_reg <= `SPFIC_DIV_RST;
         off_reg <= '0;
         hr_reg <= `SPFIC_HR_MIN;
         ctx_reg <= '0;
         crx_reg <= '0;
         id_reg <= '0;
      end else if (ce && wr) begin
         unique case (addr)
            `SPFIC_A_CFG: cfg_reg <= spfic_cfg_t'(wdata[$bits(spfic_cfg_t)-1:0]);
            `SPFIC_A_DIV: begin
               if (wdata[19:0] < `SPFIC_DIV_MIN) begin
                  div_reg <= `SPFIC_DIV_MIN;
               end else if (wdata[19:0] > `SPFIC_DIV_MAX) begin
                  div_reg <= `SPFIC_DIV_MAX;
               end else begin
                  div_reg <= wdata[19:0];
               end
            end
            `SPFIC_A_TMO: off_reg <= (wdata[6:0] > `SPFIC_OFF_MAX) ?
               `SPFIC_OFF_MAX : wdata[6:0];
            `SPFIC_A_COL: begin
               ctx_reg <= (wdata[9:0] > `SPFIC_COL_MAX) ?
                  `SPFIC_COL_MAX : wdata[9:0];
               crx_reg <= (wdata[25:16] > `SPFIC_COL_MAX) ?
                  `SPFIC_COL_MAX : wdata[25:16];
            end
            `SPFIC_A_RST: begin
               if (wdata[6:0] > `SPFIC_HR_MAX) begin
                  hr_reg <= `SPFIC_HR_MAX;
               end else if (wdata[6:0] < `SPFIC_HR_MIN) begin
                  hr_reg <= `SPFIC_HR_MIN;
               end else begin
                  hr_reg <= wdata[6:0];
               end
            end
            `SPFIC_A_ID: id_reg <= wdata[15:0];
            default: ;
         endcase
      end
   end
   // auto mode: the attached device's wiring strap picks the duplex
   always_comb begin
      eff_if = cfg_reg.intf;
      if (cfg_reg.intf == SPFIC_IF_AUTO) begin
         eff_if = dev_4wire ? SPFIC_IF_422 : SPFIC_IF_485;
      end
   end
   assign half = (eff_if == SPFIC_IF_485);
   // shared tick generators: bit sample tick at 16x, millisecond
   logic [15:0] bdiv_reg;
   logic tick16;
   logic [17:0] ms_cnt_reg;
   logic ms_tick;
   assign tick16 = (bdiv_reg == '0);
   assign ms_tick = (ms_cnt_reg == '0);
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         bdiv_reg <= '0;
         ms_cnt_reg <= '0;
      end else if (ce) begin
         // bit period is the divisor rounded down to a multiple of 16 clocks, so 300 bps needs all 20 bits
         bdiv_reg <= tick16 ? div_reg[19:4] - 16'h0001 :
            bdiv_reg - 1'b1;
         ms_cnt_reg <= ms_tick ? 18'(`SPFIC_MS_CYC - 1) : ms_cnt_reg - 1'b1;
      end
   end
   // character width helpers
   logic [3:0] nbits;
   assign nbits = 4'd5 + {2'b00, cfg_reg.dbits};
   function automatic logic par_bit(input logic [7:0] d, input logic [3:0] n,
                                    input spfic_par_t p);
      logic x;
      x = ^(d & (8'hFF >> (4'd8 - n)));
      unique case (p)
         SPFIC_PAR_EVEN: par_bit = x;
         SPFIC_PAR_ODD: par_bit = ~x;
         SPFIC_PAR_MARK: par_bit = 1'b1;
         default: par_bit = 1'b0;
      endcase
   endfunction
   // receiver
   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PAR, RX_STOP}
      spfic_rx_t;
   spfic_rx_t rx_st_reg;
   logic [3:0] rx_ph_reg, rx_n_reg;
   logic [7:0] rx_sh_reg;
   logic rx_perr_reg, rx_ferr_reg, rx_done;
   logic rx_gate;
   // half duplex deafens the receiver while our own driver is on
   assign rx_gate = half && line.de;
   assign rx_done = ce && tick16 && rx_st_reg == RX_STOP && rx_ph_reg == 4'hF;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rx_st_reg <= RX_IDLE;
         rx_ph_reg <= '0;
         rx_n_reg <= '0;
         rx_sh_reg <= '0;
         rx_perr_reg <= 1'b0;
         rx_ferr_reg <= 1'b0;
      end else if (ce && tick16) begin
         rx_ph_reg <= rx_ph_reg + 1'b1;
         unique case (rx_st_reg)
            RX_IDLE: begin
               rx_ph_reg <= '0;
               if (!rxd && !rx_gate) begin
                  rx_st_reg <= RX_START;
               end
            end
            RX_START: if (rx_ph_reg == 4'h7) begin
               rx_ph_reg <= '0;
               rx_n_reg <= '0;
               rx_st_reg <= rxd ? RX_IDLE : RX_DATA;
            end
            RX_DATA: if (rx_ph_reg == 4'hF) begin
               rx_sh_reg <= {rxd, rx_sh_reg[7:1]};
               rx_n_reg <= rx_n_reg + 1'b1;
               if (rx_n_reg == nbits - 1'b1) begin
                  rx_st_reg <= (cfg_reg.parity == SPFIC_PAR_NONE) ?
                     RX_STOP : RX_PAR;
               end
            end
            RX_PAR: if (rx_ph_reg == 4'hF) begin
               rx_perr_reg <= rxd != par_bit(rx_sh_reg >> (4'd8 - nbits),
                  nbits, cfg_reg.parity);
               rx_st_reg <= RX_STOP;
            end
            RX_STOP: if (rx_ph_reg == 4'hF) begin
               rx_ferr_reg <= !rxd; // only the first stop is checked
               rx_st_reg <= RX_IDLE;
            end
            default: rx_st_reg <= RX_IDLE;
         endcase
      end
   end
   // received characters queue toward the network side
   logic rxq_valid, rxq_ready, rxq_in_ready;
   logic [7:0] rxq_data;
   spfic_fifo #(.WIDTH(8), .DEPTH(`SPFIC_FIFO_D)) u_rxq (
      .mclk(mclk), .rstn(rstn), .ce(ce),
      .in_valid(rx_done), .in_ready(rxq_in_ready),
      .in_data(rx_sh_reg >> (4'd8 - nbits)),
      .out_valid(rxq_valid), .out_ready(rxq_ready), .out_data(rxq_data));
   // software pops the queue by reading the data register
   assign rxq_ready = rd && addr == `SPFIC_A_RXD;
   // transmitter; source is the report engine first, then software
   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_PAR, TX_STOP}
      spfic_tx_t;
   spfic_tx_t tx_st_reg;
   logic [3:0] tx_ph_reg, tx_n_reg;
   logic [7:0] tx_sh_reg;
   logic tx_par_reg, tx_stop2_reg;
   logic txq_valid, txq_ready, txq_in_ready, tx_wr;
   logic [7:0] txq_data;
   logic cts_ok, tx_take;
   logic [3:0] rpt_idx_reg;
   logic [2:0] dig_n_reg;
   logic [7:0] rpt_byte;
   logic rpt_busy, rpt_go;
   assign tx_wr = ce && wr && addr == `SPFIC_A_TXD;
   spfic_fifo #(.WIDTH(8), .DEPTH(`SPFIC_FIFO_D)) u_txq (
      .mclk(mclk), .rstn(rstn), .ce(ce),
      .in_valid(tx_wr), .in_ready(txq_in_ready), .in_data(wdata[7:0]),
      .out_valid(txq_valid), .out_ready(txq_ready), .out_data(txq_data));
   assign cts_ok = (eff_if != SPFIC_IF_232HS) || cts;
   assign rpt_busy = rpt_idx_reg != `SPFIC_RPT_LEN;
   // report waits for its digits, and goes ahead of queued data
   assign rpt_go = rpt_busy && dig_n_reg == '0;
   assign tx_take = ce && tick16 && tx_st_reg == TX_IDLE && cts_ok &&
      (rpt_go || (!rpt_busy && txq_valid));
   assign txq_ready = tx_take && !rpt_busy;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         tx_st_reg <= TX_IDLE;
         tx_ph_reg <= '0;
         tx_n_reg <= '0;
         tx_sh_reg <= '0;
         tx_par_reg <= 1'b0;
         tx_stop2_reg <= 1'b0;
      end else if (ce && tick16) begin
         tx_ph_reg <= tx_ph_reg + 1'b1;
         unique case (tx_st_reg)
            TX_IDLE: begin
               tx_ph_reg <= '0;
               if (tx_take) begin
                  tx_sh_reg <= rpt_busy ? rpt_byte : txq_data;
                  tx_par_reg <= par_bit(rpt_busy ? rpt_byte : txq_data,
                     nbits, cfg_reg.parity);
                  tx_stop2_reg <= cfg_reg.two_stop;
                  tx_st_reg <= TX_START;
               end
            end
            TX_START: if (tx_ph_reg == 4'hF) begin
               tx_n_reg <= '0;
               tx_st_reg <= TX_DATA;
            end
            TX_DATA: if (tx_ph_reg == 4'hF) begin
               tx_sh_reg <= tx_sh_reg >> 1;
               tx_n_reg <= tx_n_reg + 1'b1;
               if (tx_n_reg == nbits - 1'b1) begin
                  tx_st_reg <= (cfg_reg.parity == SPFIC_PAR_NONE) ?
                     TX_STOP : TX_PAR;
               end
            end
            TX_PAR: if (tx_ph_reg == 4'hF) begin
               tx_st_reg <= TX_STOP;
            end
            TX_STOP: if (tx_ph_reg == 4'hF) begin
               tx_stop2_reg <= 1'b0;
               tx_st_reg <= tx_stop2_reg ? TX_STOP : TX_IDLE;
            end
            default: tx_st_reg <= TX_IDLE;
         endcase
      end
   end
   // line pins; rts means room in half duplex it keys the driver
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         line <= '{txd: 1'b1, rts: 1'b0, de: 1'b0};
      end else if (ce) begin
         unique case (tx_st_reg)
            TX_START: line.txd <= 1'b0;
            TX_DATA: line.txd <= tx_sh_reg[0];
            TX_PAR: line.txd <= tx_par_reg;
            default: line.txd <= 1'b1;
         endcase
         unique case (eff_if)
            SPFIC_IF_232HS: line.rts <= rxq_in_ready;
            SPFIC_IF_485: line.rts <= tx_st_reg != TX_IDLE;
            default: line.rts <= 1'b0;
         endcase
         // full duplex keeps the driver on so both pairs run together
         line.de <= half ? tx_st_reg != TX_IDLE :
            eff_if == SPFIC_IF_422;
      end
   end
   // id report: five decimal digits, port letter, lf, cr
   logic [16:0] dec_reg;
   logic [7:0] dig_reg [5];
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rpt_idx_reg <= `SPFIC_RPT_LEN;
         dec_reg <= '0;
         dig_n_reg <= '0;
         for (int i = 0; i < 5; i++) begin
            dig_reg[i] <= `SPFIC_ASC0;
         end
      end else if (ce) begin
         if (sock_conn && cfg_reg.rpt_en && !rpt_busy) begin
            rpt_idx_reg <= '0;
            dec_reg <= {1'b0, id_reg};
            dig_n_reg <= 3'd5;
         end else if (dig_n_reg != '0) begin
            // one digit per cycle, least significant first
            dig_reg[dig_n_reg - 1'b1] <= `SPFIC_ASC0 + 8'(dec_reg % 17'd10);
            dec_reg <= dec_reg / 17'd10;
            dig_n_reg <= dig_n_reg - 1'b1;
         end else if (tx_take && rpt_busy) begin
            rpt_idx_reg <= rpt_idx_reg + 1'b1;
         end
      end
   end
   always_comb begin
      unique case (rpt_idx_reg)
         4'd5: rpt_byte = `SPFIC_ASCA + {6'h00, cfg_reg.port_sel};
         4'd6: rpt_byte = `SPFIC_LF;
         4'd7: rpt_byte = `SPFIC_CR;
         default: rpt_byte = (rpt_idx_reg < 4'd5) ?
            dig_reg[rpt_idx_reg[2:0]] : 8'h00;
      endcase
   end
   // idle timers in milliseconds, reloaded on each received character
   logic [16:0] off_ms_reg;
   logic [6:0] off_min_reg;
   logic [9:0] col_rx_reg, col_tx_reg;
   logic [5:0] hr_min_reg;
   logic [6:0] hr_cnt_reg;
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         off_ms_reg <= '0;
         off_min_reg <= '0;
         off_line <= 1'b0;
         hr_min_reg <= '0;
         hr_cnt_reg <= '0;
         restart_req <= 1'b0;
      end else if (ce) begin
         restart_req <= 1'b0;
         if (rx_done || sock_conn) begin
            off_ms_reg <= '0;
            off_min_reg <= '0;
            hr_min_reg <= '0;
            hr_cnt_reg <= '0;
            off_line <= 1'b0;
         end else if (ms_tick) begin
            if (off_ms_reg == 17'(`SPFIC_MIN_MS - 1)) begin
               off_ms_reg <= '0;
               if (off_reg != '0 && off_min_reg + 1'b1 >= off_reg) begin
                  off_line <= 1'b1;
               end
               off_min_reg <= off_min_reg + 1'b1;
               if (hr_min_reg == 6'(`SPFIC_HR_MIN_CNT - 1)) begin
                  hr_min_reg <= '0;
                  if (hr_cnt_reg + 1'b1 >= hr_reg) begin
                     restart_req <= 1'b1;
                     hr_cnt_reg <= '0;
                  end else begin
                     hr_cnt_reg <= hr_cnt_reg + 1'b1;
                  end
               end else begin
                  hr_min_reg <= hr_min_reg + 1'b1;
               end
            end else begin
               off_ms_reg <= off_ms_reg + 1'b1;
            end
         end
      end
   end
   // collect timers: forward after the period, at once if period is zero
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         col_rx_reg <= '0;
         col_tx_reg <= '0;
         rx_pkt_rdy <= 1'b0;
         tx_pkt_go <= 1'b0;
      end else if (ce) begin
         rx_pkt_rdy <= 1'b0;
         tx_pkt_go <= 1'b0;
         if (rx_done) begin
            col_rx_reg <= crx_reg;
            rx_pkt_rdy <= crx_reg == '0;
         end else if (ms_tick && col_rx_reg != '0) begin
            col_rx_reg <= col_rx_reg - 1'b1;
            rx_pkt_rdy <= col_rx_reg == 10'h001;
         end
         if (tx_wr) begin
            col_tx_reg <= ctx_reg;
            tx_pkt_go <= ctx_reg == '0;
         end else if (ms_tick && col_tx_reg != '0) begin
            col_tx_reg <= col_tx_reg - 1'b1;
            tx_pkt_go <= col_tx_reg == 10'h001;
         end
      end
   end
   // read port, data one cycle after the strobe
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         rdata <= '0;
      end else if (ce) begin
         rdata <= '0;
         if (rd) begin
            unique case (addr)
               `SPFIC_A_CFG: rdata <= 32'(cfg_reg);
               `SPFIC_A_DIV: rdata <= {12'h000, div_reg};
               `SPFIC_A_TMO: rdata <= {25'h0, off_reg};
               `SPFIC_A_COL: rdata <= {6'h00, crx_reg, 6'h00, ctx_reg};
               `SPFIC_A_RST: rdata <= {25'h0, hr_reg};
               `SPFIC_A_ID: rdata <= {16'h0000, id_reg};
               `SPFIC_A_RXD: rdata <= {23'h0, rxq_valid, rxq_data};
               `SPFIC_A_STS: rdata <= {24'h0, half, rpt_busy, off_line,
                  rx_perr_reg, rx_ferr_reg, txq_in_ready, rxq_valid,
                  tx_st_reg != TX_IDLE};
               default: rdata <= '0;
            endcase
         end
      end
   end
   // checks
   rts_keys_a: assert property (@(posedge mclk) disable iff (!rstn)
      ce && eff_if == SPFIC_IF_485 && tx_st_reg == TX_START |=> line.rts)
      else $error("driver not keyed while sending");
   plain_rts_a: assert property (@(posedge mclk) disable iff (!rstn)
      $past(ce) && $past(eff_if == SPFIC_IF_232) |-> !line.rts)
      else $error("handshake driven in plain mode");
   cts_hold_a: assert property (@(posedge mclk) disable iff (!rstn)
      eff_if == SPFIC_IF_232HS && !cts |-> !tx_take)
      else $error("sent while cts withheld");
   lf_byte_a: assert property (@(posedge mclk) disable iff (!rstn)
      rpt_idx_reg == 4'd6 |-> rpt_byte == 8'h0A)
      else $error("bad line feed");
   cr_byte_a: assert property (@(posedge mclk) disable iff (!rstn)
      rpt_idx_reg == 4'd7 |-> rpt_byte == 8'h0D)
      else $error("bad carriage return");
   rpt_start_a: assert property (@(posedge mclk) disable iff (!rstn)
      ce && sock_conn && cfg_reg.rpt_en && !rpt_busy |=> rpt_idx_reg == '0)
      else $error("report not started");
   dig_wait_a: assert property (@(posedge mclk) disable iff (!rstn)
      dig_n_reg != '0 |-> !tx_take)
      else $error("report sent before digits built");
   off_clear_a: assert property (@(posedge mclk) disable iff (!rstn)
      rx_done |=> !off_line)
      else $error("off-line kept after input");
   off_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
      off_reg == '0 && !off_line |=> !off_line)
      else $error("timeout fired while disabled");
   col_zero_a: assert property (@(posedge mclk) disable iff (!rstn)
      rx_done && crx_reg == '0 |=> rx_pkt_rdy)
      else $error("zero collect not immediate");
   rx_char_c: cover property (@(posedge mclk) disable iff (!rstn) rx_done);
   rpt_c: cover property (@(posedge mclk) disable iff (!rstn)
      rpt_idx_reg == 4'd7 && tx_take);
   off_c: cover property (@(posedge mclk) disable iff (!rstn)
      $rose(off_line));
endmodule
`default_nettype wire

// *** sim/spfic_partner.sv ***
// serial device model facing the port's line pins
`default_nettype none
module spfic_partner #(
   parameter int BIT = 256
) (
   // clocking
   input wire logic mclk,
   // line from the port
   input wire logic txd,
   // line into the port
   output logic rxd,
   output logic cts
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] got[$];
   logic [7:0] sh;
   initial begin
      rxd = 1'b1;
      cts = 1'b1;
   end
   task automatic wait_bits(input int n);
      repeat (n * BIT) @(posedge mclk);
   endtask
   // sample mid-bit so a slightly off divisor still reads clean
   always begin
      @(negedge txd);
      repeat (BIT / 2) @(posedge mclk);
      for (int i = 0; i < 8; i++) begin
         wait_bits(1);
         sh[i] = txd;
      end
      wait_bits(1);
      got.push_back(sh);
   end
   // lsb first, optional parity bit, one stop
   task automatic send(input logic [7:0] d, input int nb, input logic pe,
      input logic pb);
      @(posedge mclk);
      rxd <= 1'b0;
      wait_bits(1);
      for (int i = 0; i < nb; i++) begin
         rxd <= d[i];
         wait_bits(1);
      end
      if (pe) begin
         rxd <= pb;
         wait_bits(1);
      end
      rxd <= 1'b1;
      wait_bits(1);
   endtask
endmodule
`default_nettype wire

// *** sim/spfic_top_tb.sv ***
// self-checking bench for the serial port block
`include "spfic_map.svh"
`default_nettype none
module spfic_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import spfic_pkg::*;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic sock_conn = 1'b0;
   logic dev_4wire = 1'b0;
   logic off_line, restart_req, rx_pkt_rdy, tx_pkt_go;
   int n_rdy = 0;
   int n_go = 0;
   int n_idle = 0;
   logic [31:0] rdata;
   logic [31:0] v;
   logic rxd;
   logic cts;
   spfic_line_t line;
   int n_mismatch = 0;
   int cmp_count = 0;
   always #2 mclk = ~mclk;
   spfic_top i_spfic_top(.mclk(mclk), .rstn(rstn), .ce(1'b1), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rxd(rxd), .cts(cts),
      .dev_4wire(dev_4wire), .line(line), .sock_conn(sock_conn),
      .off_line(off_line), .restart_req(restart_req),
      .rx_pkt_rdy(rx_pkt_rdy), .tx_pkt_go(tx_pkt_go));
   // event pulses and idle flags, tallied for the closing checks
   always @(posedge mclk) begin
      n_rdy += int'(rx_pkt_rdy === 1'b1);
      n_go += int'(tx_pkt_go === 1'b1);
      n_idle += int'(rstn && (off_line !== 1'b0 || restart_req !== 1'b0));
   end
   spfic_partner #(.BIT(256)) i_spfic_partner(.mclk(mclk), .txd(line.txd),
      .rxd(rxd), .cts(cts));
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge mclk);
      wr <= 1'b0;
   endtask
   // data stand only in the cycle after the strobe
   task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr <= a;
      rd <= 1'b1;
      @(posedge mclk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic wait_got(input int n);
      for (int i = 0; i < 3000 * n && i_spfic_partner.got.size() < n; i++)
         @(posedge mclk);
   endtask
   task automatic wait_start;
      for (int i = 0; i < 8000 && line.txd !== 1'b0; i++)
         @(posedge mclk);
   endtask
   initial begin
      #360000;
      n_mismatch++;
      give_verdict();
   end
   initial begin
      repeat (12) @(posedge mclk);
      chk({29'h0, line}, 32'h4);
      rstn <= 1'b1;
      rd_reg(`SPFIC_A_DIV, v);
      chk(v, {12'h0, `SPFIC_DIV_RST});
      rd_reg(4'hF, v);
      chk(v, 32'h0);
      wr_reg(`SPFIC_A_DIV, 32'h100);
      wr_reg(`SPFIC_A_CFG, 32'h18);
      i_spfic_partner.cts <= 1'b0;
      wr_reg(`SPFIC_A_TXD, 32'hA5);
      wait_start();
      chk({31'h0, line.rts}, 32'h0);
      wait_got(1);
      chk({24'h0, i_spfic_partner.got[0]}, 32'hA5);
      // handshake mode must hold the byte while clear-to-send is low
      wr_reg(`SPFIC_A_CFG, 32'h58);
      wr_reg(`SPFIC_A_TXD, 32'h3C);
      repeat (20 * 256) @(posedge mclk);
      chk(i_spfic_partner.got.size(), 1);
      chk({31'h0, line.rts}, 32'h1);
      i_spfic_partner.cts <= 1'b1;
      wait_got(2);
      chk({24'h0, i_spfic_partner.got[1]}, 32'h3C);
      // seven data bits, every parity mode; 0x34 has three ones
      for (int m = 0; m < 5; m++) begin
         wr_reg(`SPFIC_A_CFG, 32'h10 | m);
         i_spfic_partner.send(8'h34, 7, m != 0, 1'(5'b10010 >> m));
         v = 32'h0;
         for (int i = 0; i < 300 && v[2] !== 1'b1; i++)
            rd_reg(`SPFIC_A_STS, v);
         chk(v & 32'h18, 32'h0);
         rd_reg(`SPFIC_A_RXD, v);
         chk(v, 32'h134);
      end
      wr_reg(`SPFIC_A_CFG, 32'h98);
      wr_reg(`SPFIC_A_TXD, 32'h5A);
      wait_start();
      chk({29'h0, line.de, line.rts, line.txd}, 32'h6);
      wait_got(3);
      repeat (256) @(posedge mclk);
      chk({30'h0, line.de, line.rts}, 32'h0);
      // auto mode follows the attached device's wiring
      wr_reg(`SPFIC_A_CFG, 32'h118);
      rd_reg(`SPFIC_A_STS, v);
      chk({30'h0, v[7], line.de}, 32'h2);
      @(posedge mclk);
      dev_4wire <= 1'b1;
      rd_reg(`SPFIC_A_STS, v);
      chk({30'h0, v[7], line.de}, 32'h1);
      i_spfic_partner.got.delete();
      wr_reg(`SPFIC_A_CFG, 32'h618);
      wr_reg(`SPFIC_A_ID, 32'd12345);
      @(posedge mclk);
      sock_conn <= 1'b1;
      @(posedge mclk);
      sock_conn <= 1'b0;
      wait_got(8);
      chk(i_spfic_partner.got.size(), 8);
      for (int i = 0; i < 8; i++)
         chk({24'h0, i_spfic_partner.got[i]},
            {24'h0, 8'({"12345B", 8'h0A, 8'h0D} >> (56 - 8 * i))});
      chk(n_rdy, 5);
      chk(n_go, 3);
      chk(n_idle, 0);
      give_verdict();
   end
endmodule
`default_nettype wire
